// ---- logic/timecode_regs.vh ----
// constants for the timecode and status reporting block
`ifndef TIMECODE_REGS_VH
`define TIMECODE_REGS_VH
// host command codes
`define CMD_RD_COND      4'h0
`define CMD_RD_EVENT     4'h1
`define CMD_WR_ENABLE    4'h2
`define CMD_WR_PTR       4'h3
`define CMD_WR_NTR       4'h4
`define CMD_PRESET       4'h5
`define CMD_USER_SET     4'h6
`define CMD_USER_CLR     4'h7
`define CMD_FMT_SELECT   4'h8
`define CMD_FMT_QUERY    4'h9
`define CMD_TC_QUERY     4'hA
`define CMD_RD_STD_EVENT 4'hB
`define CMD_WR_STD_EN    4'hC
// group select
`define GRP_QUES         2'h0
`define GRP_OPER         2'h1
`define GRP_PWRUP        2'h2
// factory defaults
`define QUES_PTR_DEF     16'h0000
`define QUES_NTR_DEF     16'h0000
`define QUES_EN_DEF      16'h0001
`define QUES_ALM_DEF     16'h0001
`define OPER_PTR_DEF     16'h007F
`define OPER_NTR_DEF     16'h0000
`define OPER_EN_DEF      16'h0024
`define OPER_ALM_DEF     16'h0024
`define PWR_PTR_DEF      16'h0007
`define PWR_NTR_DEF      16'h0000
`define PWR_EN_DEF       16'h0007
`define PWR_ALM_DEF      16'h0000
`define STD_EN_DEF       8'h00
`define STD_EVENT_RST    8'h80
`define STD_USED_MASK    8'hB8
// bit positions
`define STD_BIT_DEV      3
`define STD_BIT_EXEC     4
`define STD_BIT_CMD      5
`define QUES_BIT_TSET    0
`define QUES_BIT_USER    1
// message layout
`define FMT_SECONDS      1'b0
`define FMT_CALENDAR     1'b1
`define SECS_BODY_LEN    5'd17
`define CAL_BODY_LEN     5'd21
`define SECS_DIGIT0      5'd4
`define CAL_DIGIT0       5'd2
`define TAIL_LEN         5'd5
// ascii
`define CH_T             8'h54
`define CH_1             8'h31
`define CH_2             8'h32
`define CH_HASH          8'h23
`define CH_H             8'h48
`define CH_F             8'h46
`define CH_0             8'h30
`define CH_PLUS          8'h2B
`define CH_MINUS         8'h2D
`define CH_A_LESS10      8'h37
`define CH_CR            8'h0D
`define CH_LF            8'h0A
// leap codes
`define LEAP_NONE        2'h0
`define LEAP_POS         2'h1
`define LEAP_NEG         2'h2
`endif

// ---- logic/status_group.v ----
// one status register group: condition, transition filters, event, enable
`timescale 1ns/10ps
module status_group #(
    parameter       W       = 16,
    parameter [15:0] PTR_DEF = 16'h0000,
    parameter [15:0] NTR_DEF = 16'h0000,
    parameter [15:0] EN_DEF  = 16'h0000,
    parameter [15:0] ALM_DEF = 16'h0000
) (
    input  wire         clk,
    input  wire         sys_rst,
    input  wire [W-1:0] cond,
    input  wire [W-1:0] event_set,
    input  wire         preset,
    input  wire         wr_enable,
    input  wire         wr_ptr,
    input  wire         wr_ntr,
    input  wire [W-1:0] wdata,
    input  wire         rd_clear,
    output reg  [W-1:0] event_r,
    output reg  [W-1:0] cond_r,
    output reg          summary_r,
    output reg          alarm_r
);
    reg  [W-1:0] ptr_r;
    reg  [W-1:0] ntr_r;
    reg  [W-1:0] en_r;
    reg  [W-1:0] alm_r;
    wire [W-1:0] rise = cond & ~cond_r;
    wire [W-1:0] fall = ~cond & cond_r;
    wire [W-1:0] new_ev = (rise & ptr_r) | (fall & ntr_r) | event_set;
    // a new event in the clearing cycle survives the read
    wire [W-1:0] event_nxt = (rd_clear ? {W{1'b0}} : event_r) | new_ev;

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ptr_r     <= PTR_DEF[W-1:0];
            ntr_r     <= NTR_DEF[W-1:0];
            en_r      <= EN_DEF[W-1:0];
            alm_r     <= ALM_DEF[W-1:0];
            event_r   <= {W{1'b0}};
            cond_r    <= {W{1'b0}};
            summary_r <= 1'b0;
            alarm_r   <= 1'b0;
        end
        else
        begin
            cond_r    <= cond;
            event_r   <= event_nxt;
            summary_r <= |(event_nxt & en_r);
            alarm_r   <= |(event_nxt & en_r & alm_r);
            if (preset)
            begin
                ptr_r <= PTR_DEF[W-1:0];
                ntr_r <= NTR_DEF[W-1:0];
                en_r  <= EN_DEF[W-1:0];
                alm_r <= ALM_DEF[W-1:0];
            end
            else
            begin
                if (wr_enable)
                    en_r <= wdata;
                if (wr_ptr)
                    ptr_r <= wdata;
                if (wr_ntr)
                    ntr_r <= wdata;
            end
        end
    end
endmodule

// ---- logic/char_emitter.v ----
// one-stage character output register with running additive checksum
`timescale 1ns/10ps
module char_emitter (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire [7:0] in_char,
    input  wire       in_valid,
    input  wire       in_sum,
    input  wire       sum_clear,
    output wire       in_ready,
    output reg  [7:0] out_char_r,
    output reg        out_valid_r,
    input  wire       out_ready,
    output reg  [7:0] sum_r
);
    assign in_ready = ~out_valid_r | out_ready;

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_char_r  <= 8'h00;
            out_valid_r <= 1'b0;
            sum_r       <= 8'h00;
        end
        else
        begin
            if (in_ready)
            begin
                out_valid_r <= in_valid;
                if (in_valid)
                    out_char_r <= in_char;
            end
            // modulo-256 sum of every accepted body character
            if (sum_clear)
                sum_r <= 8'h00;
            else if (in_valid & in_ready & in_sum)
                sum_r <= sum_r + in_char;
        end
    end
endmodule

// ---- logic/timecode_status.v ----
// timecode reply formatter and status register groups
`timescale 1ns/10ps
`include "timecode_regs.vh"
module timecode_status (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        cmd_valid,
    input  wire [3:0]  cmd_code,
    input  wire [1:0]  cmd_group,
    input  wire [15:0] cmd_data,
    output reg         rsp_valid_r,
    output reg  [15:0] rsp_data_r,
    input  wire [31:0] gps_seconds,
    input  wire [55:0] calendar_bcd,
    input  wire [3:0]  time_fom,
    input  wire [3:0]  freq_fom,
    input  wire [1:0]  leap_pending,
    input  wire        time_valid,
    input  wire        err_device,
    input  wire        err_exec,
    input  wire        err_command,
    input  wire        time_was_set,
    input  wire        gps_locked,
    input  wire        position_hold,
    input  wire        sats_sufficient,
    input  wire        log_almost_full,
    input  wire        holdover_summary,
    input  wire        hardware_summary,
    input  wire        first_sat_tracked,
    input  wire        oven_warm,
    output wire [7:0]  tc_char,
    output wire        tc_valid,
    input  wire        tc_ready,
    output reg         tc_busy_r,
    output reg         format_r,
    output reg         alarm_r
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_BODY = 3'd1;
    localparam [2:0] ST_CKH  = 3'd2;
    localparam [2:0] ST_CKL  = 3'd3;
    localparam [2:0] ST_CR   = 3'd4;
    localparam [2:0] ST_LF   = 3'd5;

    function [7:0] hex_ascii;
        input [3:0] n;
        begin
            if (n < 4'hA)
                hex_ascii = `CH_0 + {4'h0, n};
            else
                hex_ascii = `CH_A_LESS10 + {4'h0, n};
        end
    endfunction

    function [3:0] nib_at;
        input [63:0] w;
        input [4:0]  k;
        begin
            nib_at = w[63 - 4 * k -: 4];
        end
    endfunction

    reg  [7:0]  std_event_r;
    reg  [7:0]  std_en_r;
    reg         user_r;
    reg         lock_seen_r;
    reg  [2:0]  state_r;
    reg  [4:0]  idx_r;
    reg         snap_fmt_r;
    reg  [63:0] snap_word_r;
    reg  [3:0]  snap_tfom_r;
    reg  [3:0]  snap_ffom_r;
    reg  [1:0]  snap_leap_r;
    reg         snap_srq_r;
    reg         snap_valid_r;
    reg  [7:0]  ch;
    reg  [15:0] rsp_nxt;
    reg         rsp_vld_nxt;
    reg  [2:0]  state_nxt;

    wire [15:0] q_event;
    wire [15:0] q_cond;
    wire        q_sum;
    wire        q_alarm;
    wire [15:0] o_event;
    wire [15:0] o_cond;
    wire        o_sum;
    wire        o_alarm;
    wire [15:0] p_event;
    wire [15:0] p_cond;
    wire        p_sum;
    wire        p_alarm;
    wire        em_ready;
    wire [7:0]  sum;

    wire is_rd_ev  = cmd_valid & (cmd_code == `CMD_RD_EVENT);
    wire is_wr_en  = cmd_valid & (cmd_code == `CMD_WR_ENABLE);
    wire is_wr_ptr = cmd_valid & (cmd_code == `CMD_WR_PTR);
    wire is_wr_ntr = cmd_valid & (cmd_code == `CMD_WR_NTR);
    wire preset    = cmd_valid & (cmd_code == `CMD_PRESET);
    wire sel_q     = cmd_group == `GRP_QUES;
    wire sel_o     = cmd_group == `GRP_OPER;
    wire sel_p     = cmd_group == `GRP_PWRUP;

    wire std_sum = |(std_event_r & std_en_r);
    // service request summary: any enabled summary in the status byte
    wire srq = std_sum | q_sum | o_sum;

    wire [15:0] q_cond_in = {14'h0000, user_r, 1'b0};
    wire [15:0] q_set_in  = {15'h0000, time_was_set};
    wire [15:0] o_cond_in = {9'h000, log_almost_full,
                             hardware_summary,
                             sats_sufficient,
                             position_hold,
                             holdover_summary,
                             gps_locked,
                             p_sum};
    wire [15:0] p_cond_in = {13'h0000, lock_seen_r,
                             oven_warm, first_sat_tracked};

    status_group #(
        .W       (16),
        .PTR_DEF (`QUES_PTR_DEF),
        .NTR_DEF (`QUES_NTR_DEF),
        .EN_DEF  (`QUES_EN_DEF),
        .ALM_DEF (`QUES_ALM_DEF)
    ) u_ques (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .cond      (q_cond_in),
        .event_set (q_set_in),
        .preset    (preset),
        .wr_enable (is_wr_en & sel_q),
        .wr_ptr    (is_wr_ptr & sel_q),
        .wr_ntr    (is_wr_ntr & sel_q),
        .wdata     (cmd_data),
        .rd_clear  (is_rd_ev & sel_q),
        .event_r   (q_event),
        .cond_r    (q_cond),
        .summary_r (q_sum),
        .alarm_r   (q_alarm)
    );

    status_group #(
        .W       (16),
        .PTR_DEF (`OPER_PTR_DEF),
        .NTR_DEF (`OPER_NTR_DEF),
        .EN_DEF  (`OPER_EN_DEF),
        .ALM_DEF (`OPER_ALM_DEF)
    ) u_oper (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .cond      (o_cond_in),
        .event_set (16'h0000),
        .preset    (preset),
        .wr_enable (is_wr_en & sel_o),
        .wr_ptr    (is_wr_ptr & sel_o),
        .wr_ntr    (is_wr_ntr & sel_o),
        .wdata     (cmd_data),
        .rd_clear  (is_rd_ev & sel_o),
        .event_r   (o_event),
        .cond_r    (o_cond),
        .summary_r (o_sum),
        .alarm_r   (o_alarm)
    );

    status_group #(
        .W       (16),
        .PTR_DEF (`PWR_PTR_DEF),
        .NTR_DEF (`PWR_NTR_DEF),
        .EN_DEF  (`PWR_EN_DEF),
        .ALM_DEF (`PWR_ALM_DEF)
    ) u_pwr (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .cond      (p_cond_in),
        .event_set (16'h0000),
        .preset    (preset),
        .wr_enable (is_wr_en & sel_p),
        .wr_ptr    (is_wr_ptr & sel_p),
        .wr_ntr    (is_wr_ntr & sel_p),
        .wdata     (cmd_data),
        .rd_clear  (is_rd_ev & sel_p),
        .event_r   (p_event),
        .cond_r    (p_cond),
        .summary_r (p_sum),
        .alarm_r   (p_alarm)
    );

    wire [4:0] body_len = snap_fmt_r ? `CAL_BODY_LEN : `SECS_BODY_LEN;
    wire [4:0] tail0    = body_len - `TAIL_LEN;
    wire [4:0] dig0     = snap_fmt_r ? `CAL_DIGIT0 : `SECS_DIGIT0;

    // character currently offered to the emitter
    always @*
    begin
        ch = `CH_LF;
        case (state_r)
            ST_BODY:
            begin
                if (idx_r == 5'd0)
                    ch = `CH_T;
                else if (idx_r == 5'd1)
                    ch = snap_fmt_r ? `CH_2 : `CH_1;
                else if (idx_r < dig0)
                    ch = (idx_r == 5'd2) ? `CH_HASH : `CH_H;
                else if (idx_r < tail0)
                    ch = hex_ascii(nib_at(snap_word_r, idx_r - dig0));
                else if (idx_r == tail0)
                    ch = hex_ascii(snap_tfom_r);
                else if (idx_r == tail0 + 5'd1)
                    ch = hex_ascii(snap_ffom_r);
                else if (idx_r == tail0 + 5'd2)
                begin
                    if (snap_leap_r == `LEAP_POS)
                        ch = `CH_PLUS;
                    else if (snap_leap_r == `LEAP_NEG)
                        ch = `CH_MINUS;
                    else
                        ch = `CH_0;
                end
                else if (idx_r == tail0 + 5'd3)
                    ch = `CH_0 + {7'h00, snap_srq_r};
                else
                    ch = `CH_0 + {7'h00, ~snap_valid_r};
            end
            ST_CKH:
                ch = hex_ascii(sum[7:4]);
            ST_CKL:
                ch = hex_ascii(sum[3:0]);
            ST_CR:
                ch = `CH_CR;
            default:
                ch = `CH_LF;
        endcase
    end

    always @*
    begin
        state_nxt = state_r;
        if (em_ready)
        begin
            case (state_r)
                ST_BODY:
                    if (idx_r == body_len - 5'd1)
                        state_nxt = ST_CKH;
                ST_CKH:
                    state_nxt = ST_CKL;
                ST_CKL:
                    state_nxt = ST_CR;
                ST_CR:
                    state_nxt = ST_LF;
                ST_LF:
                    state_nxt = ST_IDLE;
                default:
                    state_nxt = ST_IDLE;
            endcase
        end
    end

    char_emitter u_emit (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .in_char     (ch),
        .in_valid    (state_r != ST_IDLE),
        .in_sum      (state_r == ST_BODY),
        .sum_clear   (state_r == ST_IDLE),
        .in_ready    (em_ready),
        .out_char_r  (tc_char),
        .out_valid_r (tc_valid),
        .out_ready   (tc_ready),
        .sum_r       (sum)
    );

    // register read answers
    always @*
    begin
        rsp_vld_nxt = cmd_valid;
        rsp_nxt     = 16'h0000;
        case (cmd_code)
            `CMD_RD_COND:
                rsp_nxt = sel_q ? q_cond : (sel_o ? o_cond : (sel_p ? p_cond : 16'h0000));
            `CMD_RD_EVENT:
                rsp_nxt = sel_q ? q_event : (sel_o ? o_event : (sel_p ? p_event : 16'h0000));
            `CMD_RD_STD_EVENT:
                rsp_nxt = {8'h00, std_event_r};
            `CMD_FMT_QUERY:
                rsp_nxt = {`CH_F, format_r ? `CH_2 : `CH_1};
            default:
                rsp_vld_nxt = 1'b0;
        endcase
    end

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            std_event_r  <= `STD_EVENT_RST;
            std_en_r     <= `STD_EN_DEF;
            user_r       <= 1'b0;
            lock_seen_r  <= 1'b0;
            format_r     <= `FMT_SECONDS;
            state_r      <= ST_IDLE;
            idx_r        <= 5'd0;
            snap_fmt_r   <= `FMT_SECONDS;
            snap_word_r  <= 64'h0000000000000000;
            snap_tfom_r  <= 4'h0;
            snap_ffom_r  <= 4'h0;
            snap_leap_r  <= `LEAP_NONE;
            snap_srq_r   <= 1'b0;
            snap_valid_r <= 1'b0;
            tc_busy_r    <= 1'b0;
            rsp_valid_r  <= 1'b0;
            rsp_data_r   <= 16'h0000;
            alarm_r      <= 1'b0;
        end
        else
        begin
            rsp_valid_r <= rsp_vld_nxt;
            rsp_data_r  <= rsp_nxt;
            // error events set even in the cycle the read clears
            std_event_r <= ((cmd_valid && cmd_code == `CMD_RD_STD_EVENT) ?
                            8'h00 : std_event_r)
                         | ({7'h00, err_device} << `STD_BIT_DEV)
                         | ({7'h00, err_exec} << `STD_BIT_EXEC)
                         | ({7'h00, err_command} << `STD_BIT_CMD);
            if (cmd_valid && cmd_code == `CMD_WR_STD_EN)
                std_en_r <= cmd_data[7:0] & `STD_USED_MASK;
            else if (preset)
                std_en_r <= `STD_EN_DEF;
            if (cmd_valid && cmd_code == `CMD_USER_SET)
                user_r <= 1'b1;
            else if (cmd_valid && cmd_code == `CMD_USER_CLR)
                user_r <= 1'b0;
            if (gps_locked)
                lock_seen_r <= 1'b1;
            if (cmd_valid && cmd_code == `CMD_FMT_SELECT)
                format_r <= cmd_data[0];
            alarm_r <= q_alarm | o_alarm | p_alarm | user_r;
            state_r <= state_nxt;
            tc_busy_r <= (state_nxt != ST_IDLE);
            if (state_r == ST_BODY && em_ready)
                idx_r <= idx_r + 5'd1;
            // a query while a reply is streaming is ignored
            if (state_r == ST_IDLE && cmd_valid && cmd_code == `CMD_TC_QUERY)
            begin
                state_r      <= ST_BODY;
                tc_busy_r    <= 1'b1;
                idx_r        <= 5'd0;
                snap_fmt_r   <= format_r;
                snap_word_r  <= format_r ? {calendar_bcd, 8'h00}
                                         : {gps_seconds, 32'h00000000};
                snap_tfom_r  <= time_fom;
                snap_ffom_r  <= freq_fom;
                snap_leap_r  <= leap_pending;
                snap_srq_r   <= srq;
                snap_valid_r <= time_valid;
            end
        end
    end
endmodule

// ---- verif/host_sink.sv ----
// reply consumer standing in for the host end of the character stream
`timescale 1ns/10ps
module host_sink (
    input  wire logic       clk,
    input  wire logic [7:0] tc_char,
    input  wire logic       tc_valid,
    input  wire logic       slow,
    output logic            tc_ready
);
    logic [7:0] got[$];
    logic       ph = 1'b0;
    // slow mode stalls every other cycle so held characters get exercised
    always @(posedge clk)
    begin
        ph <= ~ph;
        tc_ready <= ~slow | ph;
        if (tc_valid && tc_ready)
            got.push_back(tc_char);
    end
endmodule

// ---- verif/timecode_status_chk.sv ----
// port-level assertions for the timecode status block
`timescale 1ns/10ps
module timecode_status_chk (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        cmd_valid,
    input wire logic [3:0]  cmd_code,
    input wire logic [1:0]  cmd_group,
    input wire logic [15:0] cmd_data,
    input wire logic        rsp_valid_r,
    input wire logic [15:0] rsp_data_r,
    input wire logic        gps_locked,
    input wire logic [7:0]  tc_char,
    input wire logic        tc_valid,
    input wire logic        tc_ready,
    input wire logic        tc_busy_r,
    input wire logic        format_r,
    input wire logic        alarm_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_read_answer:
        assert property (cmd_valid && cmd_code <= 4'h1 && cmd_group != 2'h3 |=> rsp_valid_r)
        else $error("read gave no answer");
    a_write_silent:
        assert property (cmd_valid && cmd_code inside {[4'h2:4'h8]} |=> !rsp_valid_r)
        else $error("write gave an answer");
    a_fmt_answer:
        assert property (cmd_valid && cmd_code == 4'h9
            |=> rsp_data_r == (format_r ? 16'h4632 : 16'h4631)) else $error("bad format reply");
    a_fmt_select:
        assert property (cmd_valid && cmd_code == 4'h8
            |=> {15'h0, format_r} == ($past(cmd_data) & 16'h0001)) else $error("format not set");
    a_reply_start:
        assert property (cmd_valid && cmd_code == 4'hA && !tc_busy_r
            |=> tc_busy_r ##1 (tc_valid && tc_char == 8'h54)) else $error("reply start wrong");
    a_char_hold:
        assert property (tc_valid && !tc_ready |=> tc_valid && $stable(tc_char))
        else $error("character dropped while stalled");
    a_user_alarm:
        assert property (cmd_valid && cmd_code == 4'h6 |-> ##[1:3] alarm_r)
        else $error("user condition did not alarm");
    a_lock_cond:
        assert property (cmd_valid && cmd_code == 4'h0 && cmd_group == 2'h1 && $stable(gps_locked)
            |=> rsp_data_r[1] == $past(gps_locked, 2)) else $error("lock bit wrong");
endmodule
bind timecode_status timecode_status_chk chk (.*);

// ---- verif/timecode_status_reporting_bench.sv ----
// self-checking bench for the timecode reply and status groups
`timescale 1ns/10ps
module timecode_status_reporting_bench;
    logic        clk, sys_rst, cmd_valid, time_valid, tc_ready, slow, err_device, err_exec;
    logic [3:0]  cmd_code, time_fom, freq_fom;
    logic [1:0]  cmd_group, leap_pending;
    logic [15:0] cmd_data, rsp_data_r;
    logic [31:0] gps_seconds;
    logic [55:0] calendar_bcd;
    logic        err_command, time_was_set, gps_locked, position_hold, sats_sufficient;
    logic        log_almost_full, holdover_summary, hardware_summary, first_sat_tracked;
    logic        oven_warm, rsp_valid_r, tc_valid, tc_busy_r, format_r, alarm_r;
    logic [7:0]  tc_char;
    int          failures = 0;
    int          samples_checked = 0;
    timecode_status dut (.*);
    host_sink host (.clk(clk), .tc_char(tc_char), .tc_valid(tc_valid), .slow(slow),
        .tc_ready(tc_ready));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task check(input string nm, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task cmd(input logic [3:0] c, input logic [1:0] g, input logic [15:0] d);
        @(posedge clk);
        {cmd_valid, cmd_code, cmd_group, cmd_data} <= {1'b1, c, g, d};
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask
    task rd(input logic [3:0] c, input logic [1:0] g, input logic [15:0] exp, input string nm);
        cmd(c, g, 16'h0000);
        // read data is re-evaluated every cycle, so it is taken while the answer stands
        #1;
        check("rsp_valid_r", {15'h0, rsp_valid_r}, 16'h0001);
        check(nm, rsp_data_r, exp);
    endtask
    task alm(input logic x);
        check("alarm_r", {15'h0, alarm_r}, {15'h0, x});
    endtask
    task tset;
        @(posedge clk);
        time_was_set <= 1'b1;
        @(posedge clk);
        time_was_set <= 1'b0;
        w(4);
    endtask
    function automatic logic [7:0] hx(input logic [3:0] n);
        return n < 4'hA ? 8'h30 + n : 8'h37 + n;
    endfunction
    task tc(input logic f, input logic [1:0] lp, input logic v, srq, s);
        logic [7:0] e[$];
        logic [7:0] sum;
        @(posedge clk);
        {leap_pending, time_valid, slow} <= {lp, v, s};
        cmd(4'h8, 2'h0, {15'h0, f});
        host.got.delete();
        cmd(4'hA, 2'h0, 16'h0000);
        e = {8'h54, 8'h31 + f};
        if (!f)
            e = {e, 8'h23, 8'h48};
        for (int i = (f ? 13 : 7); i >= 0; i--)
            e = {e, hx(f ? calendar_bcd[i*4 +: 4] : gps_seconds[i*4 +: 4])};
        e = {e, hx(time_fom), hx(freq_fom), lp == 2'h1 ? 8'h2B : lp == 2'h2 ? 8'h2D : 8'h30};
        e = {e, 8'h30 + srq, 8'h30 + !v};
        sum = 8'h00;
        foreach (e[k])
            sum += e[k];
        e = {e, hx(sum[7:4]), hx(sum[3:0]), 8'h0D, 8'h0A};
        for (int i = 0; i < 300 && host.got.size() < e.size(); i++)
            @(posedge clk);
        #1;
        check("tc_len", 16'(host.got.size()), 16'(e.size()));
        foreach (e[k])
            check("tc_char", {8'h0, host.got[k]}, {8'h0, e[k]});
    endtask
    initial
    begin
        repeat (25000) @(posedge clk);
        failures++;
        close_out;
    end
    initial
    begin
        sys_rst = 1'b1;
        {cmd_valid, cmd_code, cmd_group, cmd_data, slow, time_valid, leap_pending} = '0;
        {err_device, err_exec, err_command, time_was_set, gps_locked, position_hold} = '0;
        {sats_sufficient, log_almost_full, holdover_summary, hardware_summary} = '0;
        {first_sat_tracked, oven_warm} = '0;
        {time_fom, freq_fom, gps_seconds, calendar_bcd} = {8'h3B, 32'h5A3F0C9E, 56'h20240229235958};
        w(6);
        sys_rst <= 1'b0;
        rd(4'hB, 2'h0, 16'h0080, "std_event");
        rd(4'hB, 2'h0, 16'h0000, "std_event");
        @(posedge clk);
        {err_device, err_exec, err_command} <= 3'b111;
        @(posedge clk);
        {err_device, err_exec, err_command} <= 3'b000;
        w(3);
        rd(4'hB, 2'h0, 16'h0038, "std_event");
        rd(4'h9, 2'h0, 16'h4631, "fmt_query");
        cmd(4'h8, 2'h0, 16'h0001);
        rd(4'h9, 2'h0, 16'h4632, "fmt_query");
        @(posedge clk);
        {gps_locked, position_hold, sats_sufficient, log_almost_full} <= 4'hF;
        {holdover_summary, hardware_summary, first_sat_tracked, oven_warm} <= 4'hF;
        w(6);
        rd(4'h0, 2'h1, 16'h007F, "oper_cond");
        alm(1'b1);
        rd(4'h1, 2'h1, 16'h007F, "oper_event");
        rd(4'h1, 2'h2, 16'h0007, "pwr_event");
        @(posedge clk);
        {gps_locked, holdover_summary, hardware_summary} <= 3'b000;
        w(6);
        rd(4'h1, 2'h1, 16'h0000, "oper_event");
        alm(1'b0);
        rd(4'h0, 2'h1, 16'h0058, "oper_cond");
        tset;
        alm(1'b1);
        rd(4'h0, 2'h0, 16'h0000, "ques_cond");
        rd(4'h1, 2'h0, 16'h0001, "ques_event");
        cmd(4'h6, 2'h0, 16'h0000);
        w(3);
        alm(1'b1);
        rd(4'h0, 2'h0, 16'h0002, "ques_cond");
        cmd(4'h7, 2'h0, 16'h0000);
        w(3);
        alm(1'b0);
        cmd(4'h2, 2'h0, 16'h0000);
        tset;
        alm(1'b0);
        rd(4'h1, 2'h0, 16'h0001, "ques_event");
        cmd(4'h5, 2'h0, 16'h0000);
        tset;
        alm(1'b1);
        rd(4'h1, 2'h0, 16'h0001, "ques_event");
        tc(1'b0, 2'h0, 1'b1, 1'b0, 1'b0);
        tc(1'b1, 2'h1, 1'b0, 1'b0, 1'b1);
        tset;
        tc(1'b0, 2'h2, 1'b1, 1'b1, 1'b1);
        close_out;
    end
endmodule
